// File: msr_axil_slave.sv
`timescale 1ns/1ns
`include "msr_map.svh"
module msr_axil_slave #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    msr_reg_if.bus regs
);
    msr_pkg::msr_axi_s state_reg;
    msr_pkg::msr_axi_s state_next;
    logic awTake;
    logic wTake;
    logic arTake;
    logic haveAw;
    logic haveW;

    assign s_axi_awready = !state_reg.awHeld && !state_reg.bValid;
    assign s_axi_wready = !state_reg.wHeld && !state_reg.bValid;
    assign s_axi_arready = !state_reg.rValid;
    assign s_axi_bvalid = state_reg.bValid;
    assign s_axi_bresp = state_reg.bResp;
    assign s_axi_rvalid = state_reg.rValid;
    assign s_axi_rresp = state_reg.rResp;
    assign s_axi_rdata = {24'h00_0000, state_reg.rData};

    always_comb
    begin
        state_next = state_reg;
        awTake = s_axi_awvalid && s_axi_awready;
        wTake = s_axi_wvalid && s_axi_wready;
        arTake = s_axi_arvalid && s_axi_arready;
        haveAw = state_reg.awHeld || awTake;
        haveW = state_reg.wHeld || wTake;
        // Address and data may arrive in either order; the write fires once both are here
        regs.wrEn = haveAw && haveW;
        regs.wrAddr = state_reg.awHeld ? state_reg.awAddr : 32'(s_axi_awaddr);
        regs.wrData = state_reg.wHeld ? state_reg.wData : s_axi_wdata[7:0];
        regs.wrLane0 = state_reg.wHeld ? state_reg.wLane0 : s_axi_wstrb[0];
        regs.rdEn = arTake;
        regs.rdAddr = 32'(s_axi_araddr);
        if (regs.wrEn)
        begin
            state_next.awHeld = 1'b0;
            state_next.wHeld = 1'b0;
            state_next.bValid = 1'b1;
            state_next.bResp = regs.wrOk ? `MSR_RESP_OKAY : `MSR_RESP_SLVERR;
        end
        else
        begin
            if (awTake)
            begin
                state_next.awHeld = 1'b1;
                state_next.awAddr = 32'(s_axi_awaddr);
            end
            if (wTake)
            begin
                state_next.wHeld = 1'b1;
                state_next.wData = s_axi_wdata[7:0];
                state_next.wLane0 = s_axi_wstrb[0];
            end
        end
        if (state_reg.bValid && s_axi_bready)
        begin
            state_next.bValid = 1'b0;
        end
        if (arTake)
        begin
            state_next.rValid = 1'b1;
            state_next.rData = regs.rdData;
            state_next.rResp = regs.rdOk ? `MSR_RESP_OKAY : `MSR_RESP_SLVERR;
        end
        else if (state_reg.rValid && s_axi_rready)
        begin
            state_next.rValid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end
endmodule : msr_axil_slave

// File: msr_map.svh
`ifndef MSR_MAP_SVH
`define MSR_MAP_SVH

// Register indexes; byte address is four times the index
`define MSR_IDX_HOST_VOLT_A 8'hbb
`define MSR_IDX_HOST_VOLT_B 8'hbc
`define MSR_IDX_HOST_FAN 8'hbd
`define MSR_IDX_HOST_DIGITAL 8'hbe
`define MSR_IDX_HOST_GP 8'hbf
`define MSR_IDX_MGMT_VOLT_A 8'hc3
`define MSR_IDX_MGMT_VOLT_B 8'hc4
`define MSR_IDX_MGMT_FAN 8'hc5
`define MSR_IDX_MGMT_DIGITAL 8'hc6
`define MSR_IDX_CONTROL 8'hc8
`define MSR_IDX_SUMMARY 8'hc9

// Position of each status register inside a copy
`define MSR_SLOT_VOLT_A 0
`define MSR_SLOT_VOLT_B 1
`define MSR_SLOT_FAN 2
`define MSR_SLOT_DIGITAL 3
`define MSR_SLOTS 4

// Bits that exist in each register; the rest are reserved and read zero
`define MSR_MASK_VOLT_A 8'hff
`define MSR_MASK_VOLT_B 8'hf8
`define MSR_MASK_FAN 8'hff
`define MSR_MASK_DIGITAL 8'hf8

// Field positions
`define MSR_VB_FIRST_SENSE 3
`define MSR_DIG_FORCE_FULL 3
`define MSR_DIG_TERM_ONE 4
`define MSR_DIG_TERM_TWO 5
`define MSR_DIG_CODE_FAULT 6
`define MSR_DIG_CHASSIS 7
`define MSR_CTRL_SOFT_RESET 0
`define MSR_SUM_HOST_ANY 0
`define MSR_SUM_MGMT_ANY 1
`define MSR_SUM_GP_ANY 2

// Reset values
`define MSR_STATUS_RESET 8'h00
`define MSR_GP_RESET 8'h00

// Address field of the bus
`define MSR_IDX_LSB 2
`define MSR_IDX_MSB 9
`define MSR_ADDR_TOP_LSB 10

// Bus responses
`define MSR_RESP_OKAY 2'b00
`define MSR_RESP_SLVERR 2'b10

`endif

// File: msr_pkg.sv
package msr_pkg;

    typedef logic [7:0] msr_byte_t;

    // Status copy: one byte per status register
    typedef msr_byte_t [3:0] msr_copy_t;

    typedef struct packed {
        msr_copy_t hostStat;
        msr_copy_t mgmtStat;
        msr_byte_t gpLevel;
        msr_byte_t gpDrive;
    } msr_bank_s;

    typedef struct packed {
        logic awHeld;
        logic [31:0] awAddr;
        logic wHeld;
        msr_byte_t wData;
        logic wLane0;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        msr_byte_t rData;
        logic [1:0] rResp;
    } msr_axi_s;

endpackage : msr_pkg

// File: msr_reg_if.sv
`timescale 1ns/1ns
interface msr_reg_if;
    logic wrEn;
    logic [31:0] wrAddr;
    logic [7:0] wrData;
    logic wrLane0;
    logic wrOk;
    logic rdEn;
    logic [31:0] rdAddr;
    logic [7:0] rdData;
    logic rdOk;

    modport bus(
        output wrEn, wrAddr, wrData, wrLane0, rdEn, rdAddr,
        input wrOk, rdData, rdOk
    );
    modport regs(
        input wrEn, wrAddr, wrData, wrLane0, rdEn, rdAddr,
        output wrOk, rdData, rdOk
    );
endinterface : msr_reg_if

// File: msr_status_bank.sv
// Functional notes
// R01 - Voltage status A: bits 0-7 flag three 12 V rails, 3.3 V, senses 15, 19, 5 V, 23.
// R02 - Voltage status B: bits 2:0 reserved; 3-5 senses 24-26; 6 second, 7 first 1.5 V.
// R03 - Fan status bit n flags a fault on fan channel n+1, eight channels.
// R04 - Digital status: bits 2:0 reserved; bit 3 force-full-speed; bits 4,5 termination senses.
// R05 - Digital status bit 6 voltage-code compare fault, bit 7 chassis intrusion.
// R06 - General-purpose register shows pins one to eight; readable and writable.
// R07 - Management copies of voltage, fan, digital status at own addresses, same layout.
// R08 - Status clears to zero at power-on and on software reset; no lock.
// R09 - Writes to read-only status and reserved bits ignored; reserved bits read zero.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`include "msr_map.svh"
module msr_status_bank #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] voltTripA,
    input wire logic [4:0] voltTripB,
    input wire logic [7:0] fanFault,
    input wire logic forceFullSpeedInput,
    input wire logic terminationSenseOne,
    input wire logic terminationSenseTwo,
    input wire logic voltageCodeCompareFault,
    input wire logic chassisIntrusion,
    input wire logic [7:0] gpPinLevel,
    output logic [7:0] gpPinDrive
);
    msr_reg_if regs();

    msr_pkg::msr_bank_s bank_reg;
    msr_pkg::msr_bank_s bank_next;
    msr_pkg::msr_copy_t events;
    msr_pkg::msr_copy_t masks;
    msr_pkg::msr_copy_t hostClr;
    msr_pkg::msr_copy_t mgmtClr;
    logic [7:0] wrIdx;
    logic [7:0] rdIdx;
    logic wrInRange;
    logic rdInRange;
    logic softReset;
    logic gpWrite;

    msr_axil_slave #(
        .ADDR_W(ADDR_W)
    ) msr_axil_slave_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .regs(regs)
    );

    assign gpPinDrive = bank_reg.gpDrive;

    // Map of a slot index back to its register index in each copy
    function automatic logic [7:0] hostIndex(input int slot);
        case (slot)
            `MSR_SLOT_VOLT_A: hostIndex = `MSR_IDX_HOST_VOLT_A;
            `MSR_SLOT_VOLT_B: hostIndex = `MSR_IDX_HOST_VOLT_B;
            `MSR_SLOT_FAN: hostIndex = `MSR_IDX_HOST_FAN;
            default: hostIndex = `MSR_IDX_HOST_DIGITAL;
        endcase
    endfunction : hostIndex

    function automatic logic [7:0] mgmtIndex(input int slot);
        case (slot)
            `MSR_SLOT_VOLT_A: mgmtIndex = `MSR_IDX_MGMT_VOLT_A;
            `MSR_SLOT_VOLT_B: mgmtIndex = `MSR_IDX_MGMT_VOLT_B;
            `MSR_SLOT_FAN: mgmtIndex = `MSR_IDX_MGMT_FAN;
            default: mgmtIndex = `MSR_IDX_MGMT_DIGITAL;
        endcase
    endfunction : mgmtIndex

    // Condition inputs arranged as the status bytes they feed
    always_comb
    begin
        events = '0;
        events[`MSR_SLOT_VOLT_A] = voltTripA; // see R01
        events[`MSR_SLOT_VOLT_B][7:`MSR_VB_FIRST_SENSE] = voltTripB; // see R02
        events[`MSR_SLOT_FAN] = fanFault; // see R03
        events[`MSR_SLOT_DIGITAL][`MSR_DIG_FORCE_FULL] = forceFullSpeedInput; // see R04
        events[`MSR_SLOT_DIGITAL][`MSR_DIG_TERM_ONE] = terminationSenseOne; // see R04
        events[`MSR_SLOT_DIGITAL][`MSR_DIG_TERM_TWO] = terminationSenseTwo; // see R04
        events[`MSR_SLOT_DIGITAL][`MSR_DIG_CODE_FAULT] = voltageCodeCompareFault; // see R05
        events[`MSR_SLOT_DIGITAL][`MSR_DIG_CHASSIS] = chassisIntrusion; // see R05
        masks[`MSR_SLOT_VOLT_A] = `MSR_MASK_VOLT_A;
        masks[`MSR_SLOT_VOLT_B] = `MSR_MASK_VOLT_B;
        masks[`MSR_SLOT_FAN] = `MSR_MASK_FAN;
        masks[`MSR_SLOT_DIGITAL] = `MSR_MASK_DIGITAL;
    end

    // Address decode
    always_comb
    begin
        wrIdx = regs.wrAddr[`MSR_IDX_MSB:`MSR_IDX_LSB];
        rdIdx = regs.rdAddr[`MSR_IDX_MSB:`MSR_IDX_LSB];
        wrInRange = regs.wrAddr[31:`MSR_ADDR_TOP_LSB] == '0;
        rdInRange = regs.rdAddr[31:`MSR_ADDR_TOP_LSB] == '0;
        softReset = regs.wrEn && wrInRange && regs.wrLane0 && wrIdx == `MSR_IDX_CONTROL
            && regs.wrData[`MSR_CTRL_SOFT_RESET];
        gpWrite = regs.wrEn && wrInRange && regs.wrLane0 && wrIdx == `MSR_IDX_HOST_GP;
    end

    // Mapped indexes answer OKAY; writes to read-only ones are accepted and dropped
    always_comb
    begin
        regs.wrOk = 1'b0;
        if (wrInRange)
        begin
            case (wrIdx)
                `MSR_IDX_HOST_VOLT_A, `MSR_IDX_HOST_VOLT_B, `MSR_IDX_HOST_FAN,
                `MSR_IDX_HOST_DIGITAL, `MSR_IDX_HOST_GP, `MSR_IDX_MGMT_VOLT_A,
                `MSR_IDX_MGMT_VOLT_B, `MSR_IDX_MGMT_FAN, `MSR_IDX_MGMT_DIGITAL,
                `MSR_IDX_CONTROL, `MSR_IDX_SUMMARY: regs.wrOk = 1'b1; // see R09
                default: regs.wrOk = 1'b0;
            endcase
        end
    end

    // Read mux; status bytes are shown before the read clears them
    always_comb
    begin
        regs.rdData = 8'h00;
        regs.rdOk = 1'b0;
        if (rdInRange)
        begin
            regs.rdOk = 1'b1;
            case (rdIdx)
                `MSR_IDX_HOST_VOLT_A: regs.rdData = bank_reg.hostStat[`MSR_SLOT_VOLT_A]; // see R01
                `MSR_IDX_HOST_VOLT_B: regs.rdData = bank_reg.hostStat[`MSR_SLOT_VOLT_B]; // see R02
                `MSR_IDX_HOST_FAN: regs.rdData = bank_reg.hostStat[`MSR_SLOT_FAN]; // see R03
                `MSR_IDX_HOST_DIGITAL: regs.rdData = bank_reg.hostStat[`MSR_SLOT_DIGITAL];
                `MSR_IDX_HOST_GP: regs.rdData = bank_reg.gpLevel; // see R06
                `MSR_IDX_MGMT_VOLT_A: regs.rdData = bank_reg.mgmtStat[`MSR_SLOT_VOLT_A]; // see R07
                `MSR_IDX_MGMT_VOLT_B: regs.rdData = bank_reg.mgmtStat[`MSR_SLOT_VOLT_B]; // see R07
                `MSR_IDX_MGMT_FAN: regs.rdData = bank_reg.mgmtStat[`MSR_SLOT_FAN]; // see R07
                `MSR_IDX_MGMT_DIGITAL: regs.rdData = bank_reg.mgmtStat[`MSR_SLOT_DIGITAL];
                `MSR_IDX_CONTROL: regs.rdData = 8'h00;
                `MSR_IDX_SUMMARY:
                begin
                    regs.rdData[`MSR_SUM_HOST_ANY] = |bank_reg.hostStat;
                    regs.rdData[`MSR_SUM_MGMT_ANY] = |bank_reg.mgmtStat;
                    regs.rdData[`MSR_SUM_GP_ANY] = |bank_reg.gpLevel;
                end
                default: regs.rdOk = 1'b0;
            endcase
        end
    end

    // Sticky status per copy; a read clears only the copy that was read
    always_comb
    begin
        bank_next = bank_reg;
        hostClr = '0;
        mgmtClr = '0;
        for (int s = 0; s < `MSR_SLOTS; s++)
        begin
            if (regs.rdEn && rdInRange && rdIdx == hostIndex(s))
            begin
                hostClr[s] = 8'hff;
            end
            if (regs.rdEn && rdInRange && rdIdx == mgmtIndex(s))
            begin
                mgmtClr[s] = 8'hff;
            end
            if (softReset)
            begin
                hostClr[s] = 8'hff; // see R08
                mgmtClr[s] = 8'hff; // see R08
            end
            // Set wins over clear; reserved bits never set
            bank_next.hostStat[s] = ((bank_reg.hostStat[s] & ~hostClr[s]) | events[s])
                & masks[s]; // see R09
            bank_next.mgmtStat[s] = ((bank_reg.mgmtStat[s] & ~mgmtClr[s]) | events[s])
                & masks[s]; // see R07
        end
        bank_next.gpLevel = gpPinLevel; // see R06
        if (gpWrite)
        begin
            bank_next.gpDrive = regs.wrData; // see R06
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            bank_reg.hostStat <= {`MSR_SLOTS{`MSR_STATUS_RESET}}; // see R08
            bank_reg.mgmtStat <= {`MSR_SLOTS{`MSR_STATUS_RESET}}; // see R08
            bank_reg.gpLevel <= `MSR_GP_RESET;
            bank_reg.gpDrive <= `MSR_GP_RESET;
        end
        else
        begin
            bank_reg <= bank_next;
        end
    end
endmodule : msr_status_bank

// File: msr_status_bank_assertions.sv
`timescale 1ns/1ns
`include "msr_map.svh"
module msr_status_bank_assertions #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] voltTripA,
    input wire logic [7:0] fanFault,
    input wire logic chassisIntrusion,
    input wire logic [7:0] gpPinDrive
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic live;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

    // Status needs one clock out of reset before a read can show it
    always_ff @(posedge clk_sys or posedge reset)
        if (reset)
            live <= 1'b0;
        else
            live <= 1'b1;

    a_reset_idle: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid
        && gpPinDrive == 8'h00) else $error("bus or drive busy after reset");
    a_write_resp_next: assert property (wrTake |=> s_axi_bvalid)
        else $error("no write response");
    a_read_resp_next: assert property (arTake |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("bad read response");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data not held");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_gp_drive_update: assert property (wrTake && s_axi_awaddr == 12'h2fc && s_axi_wstrb[0]
        |=> gpPinDrive == $past(s_axi_wdata[7:0])) else $error("gp drive not written");
    a_reserved_read_zero: assert property (arTake && (s_axi_araddr == 12'h2f0
        || s_axi_araddr == 12'h2f8 || s_axi_araddr == 12'h310 || s_axi_araddr == 12'h318)
        |=> s_axi_rdata[2:0] == 3'b000) else $error("reserved bits set");
    a_volt_sticky: assert property (live && arTake && s_axi_araddr == 12'h2ec
        |=> (s_axi_rdata[7:0] & $past(voltTripA, 2)) == $past(voltTripA, 2))
        else $error("voltage trip lost");
    a_fan_sticky: assert property (live && arTake && s_axi_araddr == 12'h2f4
        |=> (s_axi_rdata[7:0] & $past(fanFault, 2)) == $past(fanFault, 2))
        else $error("fan fault lost");
    a_mgmt_fan_sticky: assert property (live && arTake && s_axi_araddr == 12'h314
        |=> (s_axi_rdata[7:0] & $past(fanFault, 2)) == $past(fanFault, 2))
        else $error("mgmt fan fault lost");
    a_chassis_sticky: assert property (live && arTake && s_axi_araddr == 12'h2f8
        |=> !$past(chassisIntrusion, 2) || s_axi_rdata[7]) else $error("intrusion lost");
    a_unmapped_error: assert property (arTake && s_axi_araddr == 12'h300
        |=> s_axi_rresp == `MSR_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");

    c_digital_read: cover property (arTake && s_axi_araddr == 12'h2f8);
    c_error_resp: cover property (s_axi_rvalid && s_axi_rresp == `MSR_RESP_SLVERR);
    c_gp_write: cover property (wrTake && s_axi_awaddr == 12'h2fc);
endmodule : msr_status_bank_assertions

// File: msr_status_bank_tb_top.sv
`timescale 1ns/1ns
`include "msr_map.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module msr_status_bank_tb_top;
    localparam logic [1:0] OK = `MSR_RESP_OKAY;
    localparam logic [1:0] ERR = `MSR_RESP_SLVERR;
    logic clk_sys = 1'b0, reset = 1'b1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] voltTripA = '0, fanFault = '0, gpPinLevel = '0, gpPinDrive;
    logic [4:0] voltTripB = '0;
    logic forceFullSpeedInput = 1'b0, terminationSenseOne = 1'b0, terminationSenseTwo = 1'b0;
    logic voltageCodeCompareFault = 1'b0, chassisIntrusion = 1'b0;
    int n_errors = 0, comparisons = 0;

    msr_status_bank msr_status_bank_i (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .voltTripA, .voltTripB,
        .fanFault, .forceFullSpeedInput, .terminationSenseOne, .terminationSenseTwo,
        .voltageCodeCompareFault, .chassisIntrusion, .gpPinLevel, .gpPinDrive);

    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    task automatic axw(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && (aw || w || b); n++)
        begin
            @(posedge clk_sys);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            if (b && s_axi_bvalid)
                `CHK(s_axi_bresp, er)
            b = b && !s_axi_bvalid;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= b;
        end
        if (aw || w || b)
        begin
            n_errors++;
            results();
        end
        // Let an edge pass so the next request does not reassign what this one released
        @(posedge clk_sys);
    endtask : axw

    task automatic axr(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ar, r;
        ar = 1'b1;
        r = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && (ar || r); n++)
        begin
            @(posedge clk_sys);
            ar = ar && !s_axi_arready;
            if (r && s_axi_rvalid)
            begin
                `CHK(s_axi_rdata, {24'h00_0000, e})
                `CHK(s_axi_rresp, er)
            end
            r = r && !s_axi_rvalid;
            s_axi_arvalid <= ar;
            s_axi_rready <= r;
        end
        if (ar || r)
        begin
            n_errors++;
            results();
        end
        @(posedge clk_sys);
    endtask : axr

    // Value v is the expected register pattern for input group g
    task automatic drive(input int g, input logic [7:0] v);
        case (g)
            0: voltTripA <= v;
            1: voltTripB <= v[7:3];
            2: fanFault <= v;
            default: {chassisIntrusion, voltageCodeCompareFault, terminationSenseTwo,
                terminationSenseOne, forceFullSpeedInput} <= v[7:3];
        endcase
    endtask : drive

    task automatic sc_walk;
        logic [11:0] h, m;
        logic [7:0] v;
        for (int g = 0; g < 4; g++)
        begin
            h = {2'b00, 8'(8'hbb + g), 2'b00};
            m = {2'b00, 8'(8'hc3 + g), 2'b00};
            for (int i = (g % 2) * 3; i < 8; i++)
            begin
                v = 8'h01 << i;
                drive(g, v);
                @(posedge clk_sys);
                drive(g, 8'h00);
                axr(h, v, OK);
                axr(h, 8'h00, OK);
                axr(m, v, OK);
                axr(m, 8'h00, OK);
            end
            axw(h, 8'hff, 4'hf, OK);
            axr(h, 8'h00, OK);
        end
    endtask : sc_walk

    task automatic sc_misc;
        gpPinLevel <= 8'ha5;
        axw(12'h2fc, 8'h5a, 4'h1, OK);
        `CHK(gpPinDrive, 8'h5a)
        axr(12'h2fc, 8'ha5, OK);
        axw(12'h2fc, 8'hff, 4'he, OK);
        `CHK(gpPinDrive, 8'h5a)
        fanFault <= 8'hff;
        @(posedge clk_sys);
        fanFault <= 8'h00;
        axr(12'h324, 8'h07, OK);
        axw(12'h320, 8'h01, 4'h1, OK);
        axr(12'h324, 8'h04, OK);
        axr(12'h320, 8'h00, OK);
        axr(12'h2f4, 8'h00, OK);
        axr(12'h314, 8'h00, OK);
        axr(12'h300, 8'h00, ERR);
        axr(12'h6ec, 8'h00, ERR);
        axw(12'h300, 8'h11, 4'hf, ERR);
        voltTripA <= 8'h81;
        @(posedge clk_sys);
        voltTripA <= 8'h00;
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        axr(12'h2ec, 8'h00, OK);
        `CHK(gpPinDrive, 8'h00)
    endtask : sc_misc

    initial
    begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int k = 0; k < 9; k++)
            axr({2'b00, 8'(k < 5 ? 8'hbb + k : 8'hbe + k), 2'b00}, 8'h00, OK);
        sc_walk();
        sc_misc();
        results();
    end
endmodule : msr_status_bank_tb_top

bind msr_status_bank msr_status_bank_assertions #(.ADDR_W(ADDR_W)) msr_status_bank_assertions_i (
    .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .voltTripA,
    .fanFault, .chassisIntrusion, .gpPinDrive);
